// ===== core/lsbc_cfg.svh
// timing and encoding constants for the lin sbc control block
`ifndef LSBC_CFG_SVH
`define LSBC_CFG_SVH
`define LSBC_CLK_MHZ        100
`define LSBC_REARM_US       10
`define LSBC_REARM_CYC      (`LSBC_REARM_US * `LSBC_CLK_MHZ + 1)
`define LSBC_DOM_MS         20
`define LSBC_DOM_CYC        (`LSBC_DOM_MS * 1000 * `LSBC_CLK_MHZ + 1)
`define LSBC_RESET_MS       4
`define LSBC_RESET_CYC      (`LSBC_RESET_MS * 1000 * `LSBC_CLK_MHZ)
`define LSBC_RESF_US        1
`define LSBC_RESF_CYC       (`LSBC_RESF_US * `LSBC_CLK_MHZ)
`define LSBC_BLANK_CYC      64
`define LSBC_HSDEB_CYC      64
// sync reset at pin idle levels: hs, ls2, ls1, en low; wake, tx high as pulled
`define LSBC_SYNC_RST       6'h05
`endif

// ===== core/lsbc_pkg.sv
// types shared by the lin sbc control block
package lsbc_pkg;
  typedef enum logic [1:0] {
    LSBC_FAILSAFE = 2'b00,
    LSBC_NORMAL   = 2'b01,
    LSBC_SILENT   = 2'b10,
    LSBC_SLEEP    = 2'b11
  } lsbc_mode_e;
  typedef enum logic [1:0] {
    LSBC_SRC_BUS   = 2'b00,
    LSBC_SRC_LOCAL = 2'b01,
    LSBC_SRC_UV    = 2'b10,
    LSBC_SRC_NONE  = 2'b11
  } lsbc_src_e;
endpackage : lsbc_pkg

// ===== core/lsbc_drv_if.sv
// signals between the top and one low side driver channel
`timescale 1ns/10ps
interface lsbc_drv_if;
  logic ctrl;
  logic allow;
  logic normalEntry;
  logic overload;
  logic outOn;
  logic latched;
  modport top (output ctrl, output allow, output normalEntry, output overload,
               input outOn, input latched);
  modport chan (input ctrl, input allow, input normalEntry, input overload,
                output outOn, output latched);
endinterface : lsbc_drv_if

// ===== core/lsbc_low_drv.sv
// one low side driver channel: re-arm guard, blanking, latched shutdown
`timescale 1ns/10ps
`include "lsbc_cfg.svh"
module lsbc_low_drv
  import lsbc_pkg::*;
#(
  parameter int REARM_CYC = `LSBC_REARM_CYC,
  parameter int BLANK_CYC = `LSBC_BLANK_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  lsbc_drv_if.chan  drv
);
  logic [$clog2(REARM_CYC+1)-1:0] hiCnt_reg;
  logic [$clog2(BLANK_CYC+1)-1:0] blankCnt_reg;
  logic                           armed_reg;
  logic                           shut_reg;
  logic                           ctrlPrev_reg;
  logic                           on_reg;
  logic                           onNext;

  // ************************************
  // re-arm guard after normal entry
  // ************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hiCnt_reg <= '0;
      armed_reg <= 1'b0;
    end else if (drv.normalEntry && !drv.ctrl) begin
      hiCnt_reg <= '0;
      armed_reg <= 1'b0;
    end else if (drv.normalEntry) begin
      armed_reg <= 1'b1;
    end else if (!armed_reg) begin
      if (!drv.ctrl) begin
        hiCnt_reg <= '0;
      end else if (hiCnt_reg == ($bits(hiCnt_reg))'(REARM_CYC)) begin
        armed_reg <= 1'b1;
      end else begin
        hiCnt_reg <= hiCnt_reg + 1'b1;
      end
    end
  end

  // ************************************
  // overload latch, cleared on low then high
  // ************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shut_reg     <= 1'b0;
      ctrlPrev_reg <= 1'b0;
    end else begin
      ctrlPrev_reg <= drv.ctrl;
      // monitor only live after blanking has run out
      if (on_reg && drv.overload && blankCnt_reg == '0) begin
        shut_reg <= 1'b1;
      end else if (drv.ctrl && !ctrlPrev_reg) begin
        shut_reg <= 1'b0;
      end
    end
  end

  assign onNext = drv.ctrl && drv.allow && armed_reg && !shut_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      on_reg       <= 1'b0;
      blankCnt_reg <= '0;
    end else begin
      on_reg <= onNext;
      if (!on_reg) begin
        // reload so each switch-on event is blanked
        blankCnt_reg <= ($bits(blankCnt_reg))'(BLANK_CYC);
      end else if (blankCnt_reg != '0) begin
        blankCnt_reg <= blankCnt_reg - 1'b1;
      end
    end
  end

  assign drv.outOn   = on_reg;
  assign drv.latched = shut_reg;

  AST_BLANK_HOLDS: assert property (@(posedge clk) disable iff (!rstn)
    $rose(on_reg) |-> !shut_reg [*8])
    else $error("overload latched during blanking");
  AST_SHUT_OFF: assert property (@(posedge clk) disable iff (!rstn)
    $rose(shut_reg) |=> !on_reg)
    else $error("low driver on after overload latch");
endmodule : lsbc_low_drv

// ===== core/lsbc_ctrl.sv
// top of the lin sbc mode and driver control logic
//
// Notes on behaviour
// - in normal mode bus state output follows bus, high recessive, low dominant.
// - in silent mode bus state output is held high.
// - enable high selects normal mode with transmit and receive active.
// - enable falling with transmit high enters silent mode, regulator on.
// - enable falling with transmit low enters sleep mode, regulator off.
// - an open enable reads as low, keeping the transceiver out of normal.
// - supply undervoltage pulls reset low after a debounce and holds it.
// - reset stays low 4 ms after supply good before release.
// - transmit low drives dominant; transmit high leaves the bus recessive.
// - transmit low at normal entry blocks driver until high over 10 us.
// - transmit low over 20 ms forces recessive until high over 10 us.
// - sleep entry uses real transmit level even after the time-out.
// - in fail-safe the transmit pin becomes an output reporting the cause.
// - wake output inverts local wake; wake low moves sleep or silent to fail-safe.
// - in silent, fail-safe and normal wake output mirrors local wake.
// - low drivers on only with control high in normal mode, no battery undervoltage.
// - low control low at normal entry blocks driver until high over 10 us.
// - overload latches low driver off until control goes low then high.
// - short circuit monitor blanked during switch-on until full conduction.
// - high driver follows control in all modes except sleep; open reads low.
// - high driver shutdown is debounced, latched, restarts after control low.
// - start in fail-safe with regulator on; no transmit under battery undervoltage.
// - fail-safe pins code source: bus low/low, local low/high, battery high/low.
// - wake source is cleared at once when enable brings normal mode.
// - mode changes are ignored while reset is held low.
`timescale 1ns/10ps
`include "lsbc_cfg.svh"
module lsbc_ctrl
  import lsbc_pkg::*;
#(
  parameter int REARM_CYC = `LSBC_REARM_CYC,
  parameter int DOM_CYC   = `LSBC_DOM_CYC,
  parameter int RESET_CYC = `LSBC_RESET_CYC,
  parameter int RESF_CYC  = `LSBC_RESF_CYC,
  parameter int HSDEB_CYC = `LSBC_HSDEB_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       enableIn,
  input  wire logic       txdIn,
  output logic            txdOut,
  output logic            txdOe,
  output logic            rxdOut,
  input  wire logic       busDominant,
  output logic            busDriveDominant,
  input  wire logic       busWake,
  input  wire logic       batteryUv,
  input  wire logic       vccUv,
  output logic            regulatorOn,
  output logic            undervoltage_reset_n,
  input  wire logic       local_wake_in,
  output logic            wake_mirror_out,
  input  wire logic       low_drv1_ctrl,
  input  wire logic       low_drv2_ctrl,
  input  wire logic [1:0] lowOverload,
  output logic            low_drv1_out,
  output logic            low_drv2_out,
  input  wire logic       high_drv_ctrl,
  input  wire logic       highOverload,
  output logic            high_drv_out,
  output logic [1:0]      modeOut
);
  localparam int DOM_W = $clog2(DOM_CYC+1);
  localparam int RES_W = $clog2(RESET_CYC+1);

  // ************************************
  // input synchronisers
  // ************************************
  logic [5:0] syncA_reg;
  logic [5:0] syncB_reg;
  logic       enS;
  logic       txS;
  logic       wkS;
  logic       ls1S;
  logic       ls2S;
  logic       hsS;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // wake rests high so the edge detector sees no false wake after reset
      syncA_reg <= `LSBC_SYNC_RST;
      syncB_reg <= `LSBC_SYNC_RST;
    end else begin
      // a floating pin is modelled as its pull level by the pad
      syncA_reg <= {high_drv_ctrl, low_drv2_ctrl, low_drv1_ctrl,
                    local_wake_in, enableIn, txdIn};
      syncB_reg <= syncA_reg;
    end
  end
  assign {hsS, ls2S, ls1S, wkS, enS, txS} = syncB_reg;

  // ************************************
  // reset output timing
  // ************************************
  logic [RES_W-1:0] resCnt_reg;
  logic             undervoltage_reset_n_reg;
  logic             resHold;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      resCnt_reg <= '0;
      undervoltage_reset_n_reg   <= 1'b0;
    end else if (vccUv) begin
      if (!undervoltage_reset_n_reg) begin
        resCnt_reg <= '0;
      end else if (resCnt_reg == RES_W'(RESF_CYC)) begin
        undervoltage_reset_n_reg   <= 1'b0;
        resCnt_reg <= '0;
      end else begin
        resCnt_reg <= resCnt_reg + 1'b1;
      end
    end else if (undervoltage_reset_n_reg) begin
      resCnt_reg <= '0;
    end else if (resCnt_reg == RES_W'(RESET_CYC - 1)) begin
      undervoltage_reset_n_reg <= 1'b1;
    end else begin
      resCnt_reg <= resCnt_reg + 1'b1;
    end
  end
  assign resHold              = !undervoltage_reset_n_reg;
  assign undervoltage_reset_n = undervoltage_reset_n_reg;

  // ************************************
  // operating mode
  // ************************************
  lsbc_mode_e mode_reg;
  lsbc_src_e  src_reg;
  logic       enPrev_reg;
  logic       wkPrev_reg;
  logic       enFall;
  logic       wkFall;

  assign enFall = enPrev_reg && !enS;
  assign wkFall = wkPrev_reg && !wkS;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg   <= LSBC_FAILSAFE;
      src_reg    <= LSBC_SRC_NONE;
      enPrev_reg <= 1'b0;
      wkPrev_reg <= 1'b1;
    end else begin
      enPrev_reg <= enS;
      wkPrev_reg <= wkS;
      if (resHold) begin
        mode_reg <= mode_reg;
      end else begin
        unique case (mode_reg)
          LSBC_NORMAL: begin
            if (batteryUv) begin
              mode_reg <= LSBC_FAILSAFE;
              src_reg  <= LSBC_SRC_UV;
            end else if (enFall) begin
              // pin level, not the timed-out driver, picks sleep
              mode_reg <= txS ? LSBC_SILENT : LSBC_SLEEP;
            end
          end
          LSBC_FAILSAFE, LSBC_SILENT, LSBC_SLEEP: begin
            if (enS && !batteryUv) begin
              mode_reg <= LSBC_NORMAL;
              src_reg  <= LSBC_SRC_NONE;
            end else if (mode_reg != LSBC_FAILSAFE && busWake) begin
              mode_reg <= LSBC_FAILSAFE;
              src_reg  <= LSBC_SRC_BUS;
            end else if (mode_reg != LSBC_FAILSAFE && wkFall) begin
              mode_reg <= LSBC_FAILSAFE;
              src_reg  <= LSBC_SRC_LOCAL;
            end else if (enFall) begin
              mode_reg <= txS ? LSBC_SILENT : LSBC_SLEEP;
            end
          end
        endcase
      end
    end
  end

  logic normalEntry;
  logic isNormal;
  assign isNormal    = (mode_reg == LSBC_NORMAL);
  assign normalEntry = !isNormal && !resHold && enS && !batteryUv;
  assign modeOut     = mode_reg;

  // ************************************
  // transmit path: re-arm and dominant time-out
  // ************************************
  logic [DOM_W-1:0] domCnt_reg;
  logic [DOM_W-1:0] hiCnt_reg;
  logic             txArmed_reg;
  logic             busDrv_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      domCnt_reg  <= '0;
      hiCnt_reg   <= '0;
      txArmed_reg <= 1'b0;
    end else if (normalEntry) begin
      txArmed_reg <= txS;
      domCnt_reg  <= '0;
      hiCnt_reg   <= '0;
    end else if (!txS) begin
      hiCnt_reg <= '0;
      if (domCnt_reg == DOM_W'(DOM_CYC)) begin
        txArmed_reg <= 1'b0;
      end else begin
        domCnt_reg <= domCnt_reg + 1'b1;
      end
    end else begin
      domCnt_reg <= '0;
      if (hiCnt_reg == DOM_W'(REARM_CYC)) begin
        txArmed_reg <= 1'b1;
      end else if (!txArmed_reg) begin
        hiCnt_reg <= hiCnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busDrv_reg <= 1'b0;
    end else begin
      busDrv_reg <= isNormal && !batteryUv && txArmed_reg && !txS;
    end
  end
  assign busDriveDominant = busDrv_reg;

  // ************************************
  // receive, transmit-pin signalling, wake mirror, regulator
  // ************************************
  logic rxd_reg;
  logic txo_reg;
  logic txoe_reg;
  logic wko_reg;
  logic reg_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxd_reg  <= 1'b1;
      txo_reg  <= 1'b0;
      txoe_reg <= 1'b0;
      wko_reg  <= 1'b0;
      reg_reg  <= 1'b1;
    end else begin
      wko_reg  <= (mode_reg == LSBC_SLEEP) ? 1'b0 : !wkS;
      reg_reg  <= (mode_reg != LSBC_SLEEP);
      txoe_reg <= (mode_reg == LSBC_FAILSAFE);
      unique case (mode_reg)
        LSBC_NORMAL:   rxd_reg <= !busDominant;
        LSBC_SILENT:   rxd_reg <= 1'b1;
        LSBC_SLEEP:    rxd_reg <= 1'b0;
        LSBC_FAILSAFE: rxd_reg <= (src_reg == LSBC_SRC_LOCAL) || (src_reg == LSBC_SRC_NONE);
      endcase
      txo_reg <= (src_reg == LSBC_SRC_UV) || (src_reg == LSBC_SRC_NONE);
    end
  end
  assign rxdOut          = rxd_reg;
  assign txdOut          = txo_reg;
  assign txdOe           = txoe_reg;
  assign wake_mirror_out = wko_reg;
  assign regulatorOn     = reg_reg;

  // ************************************
  // low side drivers
  // ************************************
  lsbc_drv_if ld1 ();
  lsbc_drv_if ld2 ();
  assign ld1.ctrl        = ls1S;
  assign ld2.ctrl        = ls2S;
  assign ld1.allow       = isNormal && !batteryUv;
  assign ld2.allow       = isNormal && !batteryUv;
  assign ld1.normalEntry = normalEntry;
  assign ld2.normalEntry = normalEntry;
  assign ld1.overload    = lowOverload[0];
  assign ld2.overload    = lowOverload[1];

  lsbc_low_drv #(.REARM_CYC(REARM_CYC)) uLow1 (.clk(clk), .rstn(rstn), .drv(ld1));
  lsbc_low_drv #(.REARM_CYC(REARM_CYC)) uLow2 (.clk(clk), .rstn(rstn), .drv(ld2));
  assign low_drv1_out = ld1.outOn;
  assign low_drv2_out = ld2.outOn;

  // ************************************
  // high side driver with debounced latch
  // ************************************
  logic [$clog2(HSDEB_CYC+1)-1:0] hsDeb_reg;
  logic                           hsShut_reg;
  logic                           hsOn_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hsDeb_reg  <= '0;
      hsShut_reg <= 1'b0;
      hsOn_reg   <= 1'b0;
    end else begin
      if (!highOverload || !hsOn_reg) begin
        hsDeb_reg <= '0;
      end else if (hsDeb_reg == ($bits(hsDeb_reg))'(HSDEB_CYC)) begin
        hsShut_reg <= 1'b1;
      end else begin
        hsDeb_reg <= hsDeb_reg + 1'b1;
      end
      if (!hsS && !(highOverload && hsOn_reg)) begin
        hsShut_reg <= 1'b0;
      end
      hsOn_reg <= hsS && !hsShut_reg && (mode_reg != LSBC_SLEEP);
    end
  end
  assign high_drv_out = hsOn_reg;

  // ************************************
  // checks
  // ************************************
  AST_RXD_SILENT: assert property (@(posedge clk) disable iff (!rstn)
    $past(mode_reg) == LSBC_SILENT |-> rxdOut)
    else $error("bus state output not high in silent");
  AST_RXD_NORMAL: assert property (@(posedge clk) disable iff (!rstn)
    $past(mode_reg) == LSBC_NORMAL |-> rxdOut == !$past(busDominant))
    else $error("bus state output does not follow bus");
  AST_SLEEP_ENTRY: assert property (@(posedge clk) disable iff (!rstn)
    isNormal && !resHold && !batteryUv && enFall && !txS |=> mode_reg == LSBC_SLEEP)
    else $error("sleep not entered");
  AST_SILENT_ENTRY: assert property (@(posedge clk) disable iff (!rstn)
    isNormal && !resHold && !batteryUv && enFall && txS |=> mode_reg == LSBC_SILENT)
    else $error("silent not entered");
  AST_NO_MODE_IN_RESET: assert property (@(posedge clk) disable iff (!rstn)
    resHold |=> $stable(mode_reg))
    else $error("mode changed during reset hold");
  AST_DRV_RECESSIVE: assert property (@(posedge clk) disable iff (!rstn)
    txS |=> !busDriveDominant)
    else $error("bus driven with transmit high");
  AST_TX_ENTRY_LOW: assert property (@(posedge clk) disable iff (!rstn)
    normalEntry && !txS |=> !txArmed_reg [*2])
    else $error("driver armed at entry with transmit low");
  AST_LOW_OFF: assert property (@(posedge clk) disable iff (!rstn)
    !isNormal [*2] |-> !low_drv1_out && !low_drv2_out)
    else $error("low driver on outside normal");
  AST_HS_SLEEP: assert property (@(posedge clk) disable iff (!rstn)
    $past(mode_reg) == LSBC_SLEEP |-> !high_drv_out)
    else $error("high driver on in sleep");
  AST_WAKE_MIRROR: assert property (@(posedge clk) disable iff (!rstn)
    $past(mode_reg) != LSBC_SLEEP |-> wake_mirror_out == !$past(wkS))
    else $error("wake output does not mirror input");
  AST_SRC_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
    normalEntry |=> src_reg == LSBC_SRC_NONE)
    else $error("wake source not cleared");
  AST_LOW1_LATCH: assert property (@(posedge clk) disable iff (!rstn)
    ld1.latched |=> !low_drv1_out)
    else $error("low driver 1 on while latched");
  AST_LOW2_LATCH: assert property (@(posedge clk) disable iff (!rstn)
    ld2.latched |=> !low_drv2_out)
    else $error("low driver 2 on while latched");
endmodule : lsbc_ctrl

// ===== test/lsbc_host_model.sv
// bus wire model at the far side of the transceiver
`timescale 1ns/10ps
// ****************************************
// wired bus: pull-up recessive, any driver pulls dominant
// ****************************************
module lsbc_host_model (
  input  wire logic busDriveDominant,
  input  wire logic externalDominant,
  output logic      busDominant
);
  // released bus rests recessive through the termination pull-up
  assign busDominant = busDriveDominant | externalDominant;
endmodule : lsbc_host_model

// ===== test/lsbc_ctrl_tb_top.sv
// self-checking bench for the lin sbc control block
`timescale 1ns/10ps
module lsbc_ctrl_tb_top;
  import lsbc_pkg::*;
  // ****************************************
  // shortened counts keep the run short
  // ****************************************
  localparam int REARM = 20;
  localparam int DOM   = 300;
  localparam int RST   = 200;
  localparam int RESF  = 100;
  localparam int LIMIT = 6000;
  logic clk = 1'h0, rstn = 1'h0, enableIn = 1'h0, txdIn = 1'h1, busWake = 1'h0;
  logic batteryUv = 1'h0, vccUv = 1'h0, local_wake_in = 1'h1, highOverload = 1'h0;
  logic low_drv1_ctrl = 1'h0, low_drv2_ctrl = 1'h0, high_drv_ctrl = 1'h1;
  logic externalDominant = 1'h0;
  logic [1:0] lowOverload = 2'h0;
  logic txdOut, txdOe, rxdOut, busDominant, busDriveDominant, regulatorOn;
  logic undervoltage_reset_n, wake_mirror_out, low_drv1_out, low_drv2_out, high_drv_out;
  logic [1:0] modeOut;
  int n_mismatch = 0, n_compared = 0, cycles = 0, i;
  always #5 clk = ~clk;
  lsbc_ctrl #(.REARM_CYC(REARM), .DOM_CYC(DOM), .RESET_CYC(RST), .RESF_CYC(RESF),
    .HSDEB_CYC(64)) uut (.clk(clk), .rstn(rstn), .enableIn(enableIn), .txdIn(txdIn),
    .txdOut(txdOut), .txdOe(txdOe), .rxdOut(rxdOut), .busDominant(busDominant),
    .busDriveDominant(busDriveDominant), .busWake(busWake), .batteryUv(batteryUv),
    .vccUv(vccUv), .regulatorOn(regulatorOn), .undervoltage_reset_n(undervoltage_reset_n),
    .local_wake_in(local_wake_in), .wake_mirror_out(wake_mirror_out),
    .low_drv1_ctrl(low_drv1_ctrl), .low_drv2_ctrl(low_drv2_ctrl), .lowOverload(lowOverload),
    .low_drv1_out(low_drv1_out), .low_drv2_out(low_drv2_out), .high_drv_ctrl(high_drv_ctrl),
    .highOverload(highOverload), .high_drv_out(high_drv_out), .modeOut(modeOut));
  lsbc_host_model partner (.busDriveDominant(busDriveDominant),
    .externalDominant(externalDominant), .busDominant(busDominant));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic chk(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %b", $time, what, got);
    end
  endtask : chk
  task automatic chkMode(input lsbc_mode_e exp);
    n_compared++;
    if (modeOut !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t mode got %b want %b", $time, modeOut, exp);
    end
  endtask : chkMode
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // hang guard well above the expected run of under two thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    step(6);
    chkMode(LSBC_FAILSAFE);
    chk(undervoltage_reset_n, 1'h0, "reset out");
    rstn = 1'h1;
    step(20);
    enableIn = 1'h1;
    step(80);
    chkMode(LSBC_FAILSAFE);
    enableIn = 1'h0;
    step(RST - 130);
    chk(undervoltage_reset_n, 1'h0, "reset early");
    step(40);
    chk(undervoltage_reset_n, 1'h1, "reset release");
    chkMode(LSBC_FAILSAFE);
    chk(regulatorOn, 1'h1, "reg on");
    chk(txdOe, 1'h1, "txd oe");
    chk(high_drv_out, 1'h1, "hs failsafe");
    // normal entry with transmit held low: driver stays off
    txdIn = 1'h0;
    enableIn = 1'h1;
    step(8);
    chkMode(LSBC_NORMAL);
    chk(txdOe, 1'h0, "txd oe normal");
    chk(busDriveDominant, 1'h0, "blocked entry");
    txdIn = 1'h1;
    step(REARM + 8);
    txdIn = 1'h0;
    step(6);
    chk(busDriveDominant, 1'h1, "dominant");
    chk(rxdOut, 1'h0, "rxd dominant");
    txdIn = 1'h1;
    externalDominant = 1'h1;
    step(6);
    chk(busDriveDominant, 1'h0, "recessive");
    chk(rxdOut, 1'h0, "rxd remote dominant");
    externalDominant = 1'h0;
    step(6);
    chk(rxdOut, 1'h1, "rxd recessive");
    chk(wake_mirror_out, 1'h0, "wake mirror");
    // low drivers: re-arm guard, blanking, latched overload
    low_drv1_ctrl = 1'h1;
    low_drv2_ctrl = 1'h1;
    step(4);
    chk(low_drv1_out, 1'h0, "ls1 not armed");
    for (i = 0; i < REARM + 20 && low_drv1_out !== 1'h1; i++) step(1);
    lowOverload = 2'h3;
    step(10);
    lowOverload = 2'h0;
    step(4);
    chk(low_drv1_out, 1'h1, "ls1 blanked");
    chk(low_drv2_out, 1'h1, "ls2 blanked");
    step(100);
    lowOverload = 2'h1;
    step(10);
    lowOverload = 2'h0;
    step(10);
    chk(low_drv1_out, 1'h0, "ls1 latched");
    chk(low_drv2_out, 1'h1, "ls2 unaffected");
    low_drv1_ctrl = 1'h0;
    step(6);
    low_drv1_ctrl = 1'h1;
    step(REARM + 10);
    chk(low_drv1_out, 1'h1, "ls1 restart");
    // high driver debounced latched shutdown
    highOverload = 1'h1;
    step(10);
    highOverload = 1'h0;
    step(4);
    chk(high_drv_out, 1'h1, "hs debounce");
    highOverload = 1'h1;
    step(100);
    highOverload = 1'h0;
    step(6);
    chk(high_drv_out, 1'h0, "hs latched");
    high_drv_ctrl = 1'h0;
    step(6);
    high_drv_ctrl = 1'h1;
    step(8);
    chk(high_drv_out, 1'h1, "hs restart");
    // dominant time-out and re-arm
    txdIn = 1'h0;
    step(DOM + 10);
    chk(busDriveDominant, 1'h0, "timeout");
    txdIn = 1'h1;
    step(5);
    txdIn = 1'h0;
    step(4);
    chk(busDriveDominant, 1'h0, "short high");
    txdIn = 1'h1;
    step(REARM + 8);
    txdIn = 1'h0;
    step(6);
    chk(busDriveDominant, 1'h1, "rearmed");
    step(DOM + 10);
    enableIn = 1'h0;
    step(8);
    chkMode(LSBC_SLEEP);
    chk(regulatorOn, 1'h0, "reg off");
    chk(high_drv_out, 1'h0, "hs sleep");
    chk(low_drv1_out, 1'h0, "ls sleep");
    // local wake from sleep
    txdIn = 1'h1;
    local_wake_in = 1'h0;
    step(8);
    chkMode(LSBC_FAILSAFE);
    chk(wake_mirror_out, 1'h1, "wake high");
    chk(txdOut, 1'h0, "local src txd");
    chk(rxdOut, 1'h1, "local src rxd");
    chk(low_drv2_out, 1'h0, "ls failsafe");
    enableIn = 1'h1;
    step(8);
    chkMode(LSBC_NORMAL);
    chk(txdOe, 1'h0, "source cleared");
    chk(wake_mirror_out, 1'h1, "mirror normal");
    local_wake_in = 1'h1;
    // silent mode and bus wake
    enableIn = 1'h0;
    step(8);
    chkMode(LSBC_SILENT);
    chk(regulatorOn, 1'h1, "reg silent");
    externalDominant = 1'h1;
    step(6);
    chk(rxdOut, 1'h1, "rxd silent");
    chk(busDriveDominant, 1'h0, "no tx silent");
    externalDominant = 1'h0;
    busWake = 1'h1;
    step(2);
    busWake = 1'h0;
    step(8);
    chkMode(LSBC_FAILSAFE);
    chk(txdOut, 1'h0, "bus src txd");
    chk(rxdOut, 1'h0, "bus src rxd");
    // battery undervoltage blocks transmission and low drivers
    batteryUv = 1'h1;
    enableIn = 1'h1;
    txdIn = 1'h0;
    step(8);
    chk(busDriveDominant, 1'h0, "uv no tx");
    chk(low_drv2_out, 1'h0, "uv ls off");
    txdIn = 1'h1;
    batteryUv = 1'h0;
    step(8);
    // battery undervoltage in normal: fail-safe with its own source code
    batteryUv = 1'h1;
    step(4);
    chkMode(LSBC_FAILSAFE);
    chk(txdOut, 1'h1, "uv src txd");
    chk(rxdOut, 1'h0, "uv src rxd");
    batteryUv = 1'h0;
    step(8);
    // regulated supply undervoltage reset
    vccUv = 1'h1;
    step(RESF / 2);
    chk(undervoltage_reset_n, 1'h1, "debounce");
    step(RESF / 2 + 10);
    chk(undervoltage_reset_n, 1'h0, "uv reset");
    vccUv = 1'h0;
    step(RST - 20);
    chk(undervoltage_reset_n, 1'h0, "reset delay");
    step(30);
    chk(undervoltage_reset_n, 1'h1, "reset end");
    report_and_stop();
  end
endmodule : lsbc_ctrl_tb_top
